/* rbfm_assertions.sv */
// Checker for the receive backplane top: APB answer and link output timing.
// Assumes it is bound to rbfm_top and sees only its ports.
`timescale 1ns/1ps
module rbfm_assertions (
  input logic pclk,
  input logic presetn,
  input logic psel,
  input logic penable,
  input logic pwrite,
  input logic [11:0] paddr,
  input logic pready,
  input logic pslverr,
  input logic [31:0] prdata,
  input logic receive_clock_out,
  input logic receive_serial_out,
  input logic receive_frame_pulse_out,
  input logic muxed_bus1_oe,
  input logic muxed_bus2_oe
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // The divided clock must stay high for exactly forty pclk cycles after each rise.
  sequence rck_half;
    ##39 receive_clock_out ##1 !receive_clock_out;
  endsequence
  sequence unmapped_access;
    psel && !penable && paddr == 12'hffc ##1 penable;
  endsequence
  chk_rck_half_period: assert property ($rose(receive_clock_out) |-> rck_half)
    else $error("receive clock half period wrong");
  // Data and frame pulse are launched by the same pclk edge that raises the divided clock.
  chk_data_after_rise: assert property ($changed(receive_serial_out) |-> $rose(receive_clock_out))
    else $error("serial data changed off the clock rise");
  chk_pulse_after_rise: assert property ($changed(receive_frame_pulse_out) |-> $rose(receive_clock_out))
    else $error("frame pulse changed off the clock rise");
  chk_bus_exclusive: assert property (!(muxed_bus1_oe && muxed_bus2_oe))
    else $error("both mux buses driven");
  chk_apb_zero_wait: assert property (psel && penable |-> pready)
    else $error("ready missing in access cycle");
  chk_unmapped_err: assert property (unmapped_access |-> pslverr)
    else $error("unmapped access without error");
  chk_err_in_access: assert property (pslverr |-> psel && penable)
    else $error("error outside access cycle");
  chk_read_upper_zero: assert property (psel && penable && !pwrite |-> prdata[31:8] == 24'h0)
    else $error("upper read data not zero");
endmodule // rbfm_assertions

bind rbfm_top rbfm_assertions chk_u (
  .pclk(pclk),
  .presetn(presetn),
  .psel(psel),
  .penable(penable),
  .pwrite(pwrite),
  .paddr(paddr),
  .pready(pready),
  .pslverr(pslverr),
  .prdata(prdata),
  .receive_clock_out(receive_clock_out),
  .receive_serial_out(receive_serial_out),
  .receive_frame_pulse_out(receive_frame_pulse_out),
  .muxed_bus1_oe(muxed_bus1_oe),
  .muxed_bus2_oe(muxed_bus2_oe)
);

/* rbfm_defs.vh */
// Constants for the receive backplane block: register indices, fields, reset values and timing.
// Assumes inclusion by the single design file; holds definitions only.
`ifndef RBFM_DEFS_VH
`define RBFM_DEFS_VH
// Register indices; the APB byte address is four times the index.
`define RBFM_IDX_MODE 10'h001
`define RBFM_IDX_CTRL 10'h003
`define RBFM_IDX_FPCFG 10'h020
`define RBFM_IDX_ALMCFG 10'h02c
`define RBFM_IDX_SIGCFG 10'h040
`define RBFM_IDX_PLEN 10'h050
`define RBFM_IDX_TRUNK 10'h051
`define RBFM_IDX_STAT 10'h060
`define RBFM_IDX_CRC 10'h061
`define RBFM_IDX_SLOTOFF 10'h077
`define RBFM_IDX_PLTBL 10'h100
// Mode values of the receive interface mode register.
`define RBFM_MODE_FRAC 8'h00
`define RBFM_MODE_MUX 8'hc8
// Field positions.
`define RBFM_CTRL_EN 4
`define RBFM_CTRL_BUS 7
`define RBFM_FP_ESF 4
`define RBFM_ALM_ESF 4
`define RBFM_SIG_ESF 2
`define RBFM_PLEN_EN 0
`define RBFM_PLTBL_SUB 5
// Reset values and the idle byte.
`define RBFM_RST_REG 8'h00
`define RBFM_RST_TRUNK 8'hff
`define RBFM_IDLE_BYTE 8'hff
// Frame geometry.
`define RBFM_T1_BITS 8'd193
`define RBFM_T1_CHANS 5'd24
`define RBFM_MUX_BITS 11'd1024
// Receive clock made by this block: rate and half period in pclk cycles.
`define RBFM_PCLK_KHZ 125000
`define RBFM_RCLK_KHZ 1544
`define RBFM_RCLK_HALF ((`RBFM_PCLK_KHZ / `RBFM_RCLK_KHZ) / 2)
`endif

/* rbfm_far_end.sv */
// Behavioural system-side TDM logic: makes the mux clock and frame pulse, collects bytes.
// Assumes one framer; the mux clock stands still while run is low.
`timescale 1ns/1ps
module rbfm_far_end (
  input logic run,
  input logic receive_clock_out,
  input logic receive_serial_out,
  input logic receive_frame_pulse_out,
  input logic muxed_receive_data,
  input logic oe,
  output logic muxed_receive_clock,
  output logic muxed_receive_frame_pulse_in,
  output logic [7:0] frac_ch1,
  output logic [7:0] frac_ch2,
  output int frac_cnt,
  output logic [7:0] mux_byte,
  output logic [9:0] mux_pos,
  output int mux_cnt
);
  logic [9:0] bitn = 10'h3fe;
  logic [7:0] fsr;
  logic [7:0] msr;
  int fc = -9999;
  int mo = 0;
  initial
  begin
    muxed_receive_clock = 1'h0;
    muxed_receive_frame_pulse_in = 1'h0;
    frac_cnt = 0;
    mux_cnt = 0;
    // Odd start offset keeps the mux clock out of phase with pclk.
    #3.3;
    forever
      if (run)
      begin
        #80 muxed_receive_clock = 1'h1;
        #80 muxed_receive_clock = 1'h0;
      end
      else
        #8;
  end
  // The pulse moves on a rise so it is steady at the falling sample.
  always @(posedge muxed_receive_clock)
  begin
    bitn = bitn + 10'h001;
    muxed_receive_frame_pulse_in = (bitn == 10'h3ff);
  end
  always @(negedge muxed_receive_clock)
  begin
    mo = oe ? mo + 1 : 0;
    msr = {msr[6:0], muxed_receive_data};
    if (mo == 8)
    begin
      mux_byte = msr;
      mux_pos = bitn;
      mux_cnt++;
    end
  end
  always @(negedge receive_clock_out)
  begin
    fsr = {fsr[6:0], receive_serial_out};
    fc = receive_frame_pulse_out ? 0 : fc + 1;
    if (fc == 8)
      frac_ch1 = fsr;
    if (fc == 16)
    begin
      frac_ch2 = fsr;
      frac_cnt++;
    end
  end
endmodule // rbfm_far_end

/* rbfm_top.v */
// Receive backplane of one framer: APB registers, payload FIFO, fractional master and multiplexed outputs.
// Assumes pclk at 125 MHz, an upstream byte source in channel order 1..24, and an external
// multiplexed clock and frame pulse that are asynchronous to pclk.
//
// Function
// [RL1] Fractional mode: data and frame pulse change on rising edge of driven receive clock.
// [RL2] ESF framing keeps CRC-6 computed regardless of the mimic framing setting.
// [RL3] Payload substitution acts only while the payload control enable bit is one.
// [RL4] A channel whose table entry selects substitution outputs the trunk code instead.
// [RL5] Multiplexed mode value in the mode register runs the 8.192 Mbit/s backplane.
// [RL6] Control bit seven selects multiplexed bus one or bus two.
// [RL7] Mux outputs change on rising mux clock edge; frame pulse sampled on falling edge.
// [RL8] Seven-bit slot offset places this framer's bytes on the shared bus.
// [RL9] Alarm detector ESF setting selects the 24-frame multiframe for alarm framing.
// [RL10] Signaling buffer ESF setting takes signaling from ESF multiframe positions.
// [RL11] Framers with distinct offsets interleave bytes and never share a bus slot; here offsets that differ by a multiple of four share slots.
//
// Decided for this implementation: the APB slave port.
`timescale 1ns/1ps
`include "rbfm_defs.vh"

module rbfm_fifo #(
  parameter WIDTH = 8,
  parameter DEPTH = 8,
  parameter AW = 3
) (
  input wire pclk,
  input wire presetn,
  input wire in_valid,
  output wire in_ready,
  input wire [WIDTH-1:0] in_data,
  output wire out_valid,
  input wire out_ready,
  output wire [WIDTH-1:0] out_data,
  output wire [AW:0] level
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW:0] wp_q;
  reg [AW:0] rp_q;
  wire push = in_valid && in_ready;
  wire pop = out_valid && out_ready;
  assign level = wp_q - rp_q;
  assign in_ready = (level != DEPTH[AW:0]);
  assign out_valid = (level != {(AW+1){1'b0}});
  assign out_data = mem[rp_q[AW-1:0]];
  always @(posedge pclk)
  begin
    if (push)
      mem[wp_q[AW-1:0]] <= in_data;
  end
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      wp_q <= {(AW+1){1'b0}};
      rp_q <= {(AW+1){1'b0}};
    end
    else
    begin
      if (push)
        wp_q <= wp_q + 1'b1;
      if (pop)
        rp_q <= rp_q + 1'b1;
    end
  end
endmodule // rbfm_fifo

module rbfm_top (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output wire pready,
  output wire pslverr,
  output reg [31:0] prdata,
  input wire rx_byte_valid,
  output wire rx_byte_ready,
  input wire [7:0] rx_byte,
  output reg receive_clock_out,
  output reg receive_serial_out,
  output reg receive_frame_pulse_out,
  input wire muxed_receive_clock,
  input wire muxed_receive_frame_pulse_in,
  output reg muxed_receive_data,
  output reg muxed_receive_signaling,
  output reg muxed_bus1_oe,
  output reg muxed_bus2_oe
);
  reg [7:0] mode_q, ctrl_q, fpcfg_q, almcfg_q, sigcfg_q, plen_q, trunk_q, slotoff_q;
  reg [7:0] pltbl [1:24];
  reg pslverr_q;
  reg [2:0] ck_sync_q, fp_sync_q;
  reg ck_q, fp_q;
  reg [6:0] div_q;
  reg [10:0] bit_q;
  reg [4:0] frm_q;
  reg [7:0] shift_q;
  reg [5:0] crc_q, crc_lat_q;
  reg in_slot_q;
  reg [4:0] ch_q;
  reg mode_frac_q, mode_mux_q;
  integer i;

  wire [9:0] idx = paddr[11:2];
  wire setup = psel && !penable;
  wire wr = psel && penable && pwrite;
  wire fifo_valid;
  wire [7:0] fifo_data;
  wire [3:0] fifo_level;
  reg pop;

  rbfm_fifo #(.WIDTH(8), .DEPTH(8), .AW(3)) u_fifo (
    .pclk(pclk),
    .presetn(presetn),
    .in_valid(rx_byte_valid),
    .in_ready(rx_byte_ready),
    .in_data(rx_byte),
    .out_valid(fifo_valid),
    .out_ready(pop),
    .out_data(fifo_data),
    .level(fifo_level)
  );

  // Registered read data and error are prepared in the setup cycle, so the access phase ends at once.
  assign pready = penable;
  assign pslverr = penable && pslverr_q;

  // Table entries sit at indices one to twenty-four above the table base; the base index itself is unmapped.
  wire tbl_hit = (idx > `RBFM_IDX_PLTBL) && (idx <= `RBFM_IDX_PLTBL + 10'd24);
  wire [4:0] tbl_ch = idx[4:0];

  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata <= 32'h0000_0000;
      pslverr_q <= 1'b0;
    end
    else if (setup)
    begin
      pslverr_q <= 1'b0;
      case (idx)
        `RBFM_IDX_MODE: prdata <= {24'h000000, mode_q};
        `RBFM_IDX_CTRL: prdata <= {24'h000000, ctrl_q};
        `RBFM_IDX_FPCFG: prdata <= {24'h000000, fpcfg_q};
        `RBFM_IDX_ALMCFG: prdata <= {24'h000000, almcfg_q};
        `RBFM_IDX_SIGCFG: prdata <= {24'h000000, sigcfg_q};
        `RBFM_IDX_PLEN: prdata <= {24'h000000, plen_q};
        `RBFM_IDX_TRUNK: prdata <= {24'h000000, trunk_q};
        `RBFM_IDX_SLOTOFF: prdata <= {24'h000000, slotoff_q};
        `RBFM_IDX_STAT: prdata <= {16'h0000, 3'h0, frm_q, 2'h0, mode_mux_q, mode_frac_q, fifo_level};
        `RBFM_IDX_CRC: prdata <= {26'h0000000, crc_lat_q};
        default:
        begin
          if (tbl_hit)
            prdata <= {24'h000000, pltbl[tbl_ch]};
          else
          begin
            prdata <= 32'h0000_0000;
            pslverr_q <= 1'b1;
          end
        end
      endcase
    end
  end

  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      mode_q <= `RBFM_RST_REG;
      ctrl_q <= `RBFM_RST_REG;
      fpcfg_q <= `RBFM_RST_REG;
      almcfg_q <= `RBFM_RST_REG;
      sigcfg_q <= `RBFM_RST_REG;
      plen_q <= `RBFM_RST_REG;
      trunk_q <= `RBFM_RST_TRUNK;
      slotoff_q <= `RBFM_RST_REG;
      for (i = 1; i <= 24; i = i + 1)
        pltbl[i] <= `RBFM_RST_REG;
    end
    else if (wr)
    begin
      case (idx)
        `RBFM_IDX_MODE: mode_q <= pwdata[7:0];
        `RBFM_IDX_CTRL: ctrl_q <= pwdata[7:0];
        `RBFM_IDX_FPCFG: fpcfg_q <= pwdata[7:0];
        `RBFM_IDX_ALMCFG: almcfg_q <= pwdata[7:0];
        `RBFM_IDX_SIGCFG: sigcfg_q <= pwdata[7:0];
        `RBFM_IDX_PLEN: plen_q <= pwdata[7:0];
        `RBFM_IDX_TRUNK: trunk_q <= pwdata[7:0];
        `RBFM_IDX_SLOTOFF: slotoff_q <= {1'b0, pwdata[6:0]};
        default:
        begin
          if (tbl_hit)
            pltbl[tbl_ch] <= pwdata[7:0];
        end
      endcase
    end
  end

  // Three-stage synchronisers; a change is taken only when stages two and three agree.
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ck_sync_q <= 3'h0;
      fp_sync_q <= 3'h0;
      ck_q <= 1'b0;
      fp_q <= 1'b0;
    end
    else
    begin
      ck_sync_q <= {ck_sync_q[1:0], muxed_receive_clock};
      fp_sync_q <= {fp_sync_q[1:0], muxed_receive_frame_pulse_in};
      if (ck_sync_q[1] == ck_sync_q[2])
        ck_q <= ck_sync_q[2];
      if (fp_sync_q[1] == fp_sync_q[2])
        fp_q <= fp_sync_q[2];
    end
  end

  wire mux_rise = ck_sync_q[1] == ck_sync_q[2] && ck_sync_q[2] && !ck_q;
  wire mux_fall = ck_sync_q[1] == ck_sync_q[2] && !ck_sync_q[2] && ck_q;
  wire frac_rise = mode_frac_q && !receive_clock_out && (div_q == `RBFM_RCLK_HALF - 1);
  wire tick = mode_frac_q ? frac_rise : (mode_mux_q && mux_rise);
  wire mf_end = (frm_q == (almcfg_q[`RBFM_ALM_ESF] ? 5'd23 : 5'd11)); // [RL9]
  wire [10:0] frame_len = mode_mux_q ? `RBFM_MUX_BITS : {3'h0, `RBFM_T1_BITS};
  // A count left beyond a shorter frame by a mode change wraps at once instead of running on to 2047.
  wire [10:0] nbit = (bit_q >= frame_len - 11'd1) ? 11'd0 : bit_q + 11'd1;

  // Slot of this framer on the shared bus: every fourth slot from the offset, twenty-four slots in all.
  wire [6:0] rel_slot = nbit[9:3] - slotoff_q[6:0]; // [RL8]
  wire mux_mine = (rel_slot[1:0] == 2'b00) && (rel_slot[6:2] < `RBFM_T1_CHANS); // [RL11]
  wire [10:0] frac_rel = nbit - 11'd1;
  wire frac_mine = (nbit != 11'd0);
  wire nmine = mode_mux_q ? mux_mine : frac_mine;
  wire [4:0] nch = mode_mux_q ? rel_slot[6:2] : frac_rel[7:3];
  wire nstart = mode_mux_q ? (nbit[2:0] == 3'h0) : (frac_rel[2:0] == 3'h0);
  wire [7:0] entry = pltbl[nch + 5'd1];
  wire subst = plen_q[`RBFM_PLEN_EN] && entry[`RBFM_PLTBL_SUB]; // [RL3]
  wire [7:0] src = fifo_valid ? fifo_data : `RBFM_IDLE_BYTE;
  wire [7:0] nbyte = subst ? trunk_q : src; // [RL4]
  wire [7:0] nxt_sh = (nmine && nstart) ? nbyte : {shift_q[6:0], 1'b0};
  wire sig_frame = sigcfg_q[`RBFM_SIG_ESF] ? (frm_q == 5'd5 || frm_q == 5'd11 || frm_q == 5'd17 || frm_q == 5'd23)
                                           : (frm_q == 5'd5 || frm_q == 5'd11); // [RL10]

  // Substituted channels still pop their byte, so the stream stays aligned to channel order.
  always @*
  begin
    pop = tick && nmine && nstart && fifo_valid;
  end

  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      mode_frac_q <= 1'b0;
      mode_mux_q <= 1'b0;
      div_q <= 7'h00;
      receive_clock_out <= 1'b0;
    end
    else
    begin
      mode_frac_q <= (mode_q == `RBFM_MODE_FRAC) && ctrl_q[`RBFM_CTRL_EN];
      mode_mux_q <= (mode_q == `RBFM_MODE_MUX) && ctrl_q[`RBFM_CTRL_EN]; // [RL5]
      // The divider runs in every mode, so entering fractional mode needs no restart of it.
      if (div_q == `RBFM_RCLK_HALF - 1)
      begin
        div_q <= 7'h00;
        receive_clock_out <= mode_frac_q && !receive_clock_out;
      end
      else
        div_q <= div_q + 7'h01;
    end
  end

  // Bit engine: advances on the rising edge of whichever clock times the selected mode.
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      bit_q <= 11'h000;
      frm_q <= 5'h00;
      shift_q <= 8'h00;
      ch_q <= 5'h00;
      in_slot_q <= 1'b0;
      crc_q <= 6'h00;
      crc_lat_q <= 6'h00;
      receive_serial_out <= 1'b0;
      receive_frame_pulse_out <= 1'b0;
      muxed_receive_data <= 1'b0;
      muxed_receive_signaling <= 1'b0;
      muxed_bus1_oe <= 1'b0;
      muxed_bus2_oe <= 1'b0;
    end
    else
    begin
      // Frame alignment is taken from the pulse seen on the falling mux clock edge.
      if (mode_mux_q && mux_fall && fp_q)
        bit_q <= `RBFM_MUX_BITS - 11'd1; // [RL7]
      else if (tick)
      begin
        bit_q <= nbit;
        shift_q <= nxt_sh;
        in_slot_q <= nmine;
        ch_q <= nch;
        if (nbit == 11'd0)
        begin
          frm_q <= mf_end ? 5'd0 : frm_q + 5'd1;
          if (mf_end)
          begin
            crc_lat_q <= crc_q;
            crc_q <= 6'h00;
          end
        end
        else if (fpcfg_q[`RBFM_FP_ESF] && nmine)
          crc_q <= {crc_q[4:0], 1'b0} ^ ((crc_q[5] ^ nxt_sh[7]) ? 6'h03 : 6'h00); // [RL2]
        if (mode_frac_q)
        begin
          receive_serial_out <= nmine ? nxt_sh[7] : 1'b0; // [RL1]
          receive_frame_pulse_out <= (nbit == 11'd0); // [RL1]
        end
        else
        begin
          muxed_receive_data <= nmine ? nxt_sh[7] : 1'b0; // [RL7]
          muxed_receive_signaling <= nmine && sig_frame && nxt_sh[0];
          muxed_bus1_oe <= nmine && !ctrl_q[`RBFM_CTRL_BUS]; // [RL6]
          muxed_bus2_oe <= nmine && ctrl_q[`RBFM_CTRL_BUS]; // [RL6]
        end
      end
      // Outside multiplexed mode the shared-bus outputs rest low, so no stale bit lingers on a released bus.
      if (!mode_mux_q)
      begin
        muxed_bus1_oe <= 1'b0;
        muxed_bus2_oe <= 1'b0;
        muxed_receive_data <= 1'b0;
        muxed_receive_signaling <= 1'b0;
      end
    end
  end
endmodule // rbfm_top

/* rbfm_top_tb.sv */
// Self-checking bench for the receive backplane top: registers, FIFO, mux and fractional links.
// Assumes the far-end model makes the mux clock and frame pulse and collects bytes.
`timescale 1ns/1ps
module rbfm_top_tb;
  logic pclk = 1'h0;
  logic presetn = 1'h0;
  logic psel = 1'h0;
  logic penable = 1'h0;
  logic pwrite = 1'h0;
  logic [11:0] paddr = 12'h0;
  logic [31:0] pwdata = 32'h0;
  logic rx_byte_valid = 1'h0;
  logic [7:0] rx_byte = 8'h0;
  logic run = 1'h0;
  logic seen1, seen2, seen_sig;
  wire pready, pslverr, rx_byte_ready, receive_clock_out, receive_serial_out, receive_frame_pulse_out;
  wire muxed_receive_clock, muxed_receive_frame_pulse_in, muxed_receive_data, muxed_receive_signaling;
  wire muxed_bus1_oe, muxed_bus2_oe;
  wire oe = muxed_bus1_oe | muxed_bus2_oe;
  wire [31:0] prdata;
  wire [7:0] frac_ch1, frac_ch2, mux_byte;
  wire [9:0] mux_pos;
  int frac_cnt, mux_cnt;
  int n_errors = 0;
  int num_checks = 0;
  initial
    forever #4 pclk = ~pclk;
  rbfm_top dut_u (
    .pclk(pclk),
    .presetn(presetn),
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .paddr(paddr),
    .pwdata(pwdata),
    .pready(pready),
    .pslverr(pslverr),
    .prdata(prdata),
    .rx_byte_valid(rx_byte_valid),
    .rx_byte_ready(rx_byte_ready),
    .rx_byte(rx_byte),
    .receive_clock_out(receive_clock_out),
    .receive_serial_out(receive_serial_out),
    .receive_frame_pulse_out(receive_frame_pulse_out),
    .muxed_receive_clock(muxed_receive_clock),
    .muxed_receive_frame_pulse_in(muxed_receive_frame_pulse_in),
    .muxed_receive_data(muxed_receive_data),
    .muxed_receive_signaling(muxed_receive_signaling),
    .muxed_bus1_oe(muxed_bus1_oe),
    .muxed_bus2_oe(muxed_bus2_oe)
  );
  rbfm_far_end far_u (
    .run(run),
    .receive_clock_out(receive_clock_out),
    .receive_serial_out(receive_serial_out),
    .receive_frame_pulse_out(receive_frame_pulse_out),
    .muxed_receive_data(muxed_receive_data),
    .oe(oe),
    .muxed_receive_clock(muxed_receive_clock),
    .muxed_receive_frame_pulse_in(muxed_receive_frame_pulse_in),
    .frac_ch1(frac_ch1),
    .frac_ch2(frac_ch2),
    .frac_cnt(frac_cnt),
    .mux_byte(mux_byte),
    .mux_pos(mux_pos),
    .mux_cnt(mux_cnt)
  );
  task automatic print_verdict;
    if (n_errors == 0 && num_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  task automatic cmp(input string nm, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp)
    begin
      n_errors++;
      $display("wrong value %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic give_up(input string nm);
    cmp(nm, 32'h0, 32'h1);
    print_verdict;
  endtask
  task automatic apb(input logic w, input logic [9:0] ix, input logic [7:0] d, output logic [31:0] r,
      output logic e);
    int i;
    psel <= 1'h1;
    pwrite <= w;
    paddr <= {ix, 2'h0};
    pwdata <= {24'h0, d};
    @(posedge pclk);
    penable <= 1'h1;
    @(posedge pclk);
    for (i = 0; pready !== 1'h1 && i < 50; i++)
      @(posedge pclk);
    if (i == 50)
      give_up("apb ready timeout");
    r = prdata;
    e = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
    @(posedge pclk);
  endtask
  task automatic wr(input logic [9:0] ix, input logic [7:0] d);
    logic [31:0] r;
    logic e;
    apb(1'h1, ix, d, r, e);
  endtask
  task automatic push(input logic [7:0] b);
    int i;
    rx_byte_valid <= 1'h1;
    rx_byte <= b;
    @(posedge pclk);
    for (i = 0; rx_byte_ready !== 1'h1 && i < 50; i++)
      @(posedge pclk);
    if (i == 50)
      give_up("fifo ready timeout");
    rx_byte_valid <= 1'h0;
    @(posedge pclk);
  endtask
  function automatic int cnt(input bit m);
    return m ? mux_cnt : frac_cnt;
  endfunction
  // Waits for the far end to collect one more byte and notes which mux bus was driven meanwhile.
  task automatic wait_cnt(input bit m, input int lim);
    int c0, i;
    c0 = cnt(m);
    seen1 = 1'h0;
    seen2 = 1'h0;
    seen_sig = 1'h0;
    for (i = 0; cnt(m) == c0 && i < lim; i++)
    begin
      @(posedge pclk);
      seen1 |= muxed_bus1_oe;
      seen2 |= muxed_bus2_oe;
      seen_sig |= muxed_receive_signaling;
    end
    if (cnt(m) == c0)
      give_up("link byte timeout");
  endtask
  task automatic t_regs;
    logic [9:0] ix [7] = '{10'h001, 10'h003, 10'h020, 10'h02c, 10'h040, 10'h050, 10'h077};
    logic [7:0] wv [7] = '{8'hc8, 8'h53, 8'h30, 8'h10, 8'h04, 8'h01, 8'h83};
    logic [7:0] ev [7] = '{8'hc8, 8'h53, 8'h30, 8'h10, 8'h04, 8'h01, 8'h03};
    logic [31:0] r;
    logic e;
    apb(1'h0, 10'h051, 8'h0, r, e);
    cmp("trunk code reset", 32'hff, r);
    for (int k = 0; k < 7; k++)
    begin
      wr(ix[k], wv[k]);
      apb(1'h0, ix[k], 8'h0, r, e);
      cmp("register readback", {24'h0, ev[k]}, r);
    end
    wr(10'h3ff, 8'h55);
    apb(1'h0, 10'h3ff, 8'h0, r, e);
    cmp("unmapped read", 32'h0, r);
    cmp("unmapped error", 32'h1, {31'h0, e});
  endtask
  task automatic t_mux;
    for (int k = 0; k < 8; k++)
      push(8'ha5);
    cmp("fifo full refusal", 32'h0, {31'h0, rx_byte_ready});
    run <= 1'h1;
    wait_cnt(1'h1, 2000);
    cmp("mux byte", 32'ha5, {24'h0, mux_byte});
    cmp("mux slot end", 32'h1f, {22'h0, mux_pos});
    cmp("bus one only", 32'h1, {31'h0, seen1 & ~seen2});
    cmp("no signaling in frame two", 32'h0, {31'h0, seen_sig});
    wr(10'h003, 8'hd3);
    // Bus one stays enabled until the next mux bit; let that slot end before watching the enables again.
    repeat (40) @(posedge pclk);
    wait_cnt(1'h1, 2000);
    cmp("bus two byte", 32'ha5, {24'h0, mux_byte});
    cmp("second slot end", 32'h3f, {22'h0, mux_pos});
    cmp("bus two only", 32'h1, {31'h0, seen2 & ~seen1});
    run <= 1'h0;
  endtask
  task automatic t_frac;
    int i;
    wr(10'h003, 8'h00);
    wr(10'h001, 8'h00);
    wr(10'h051, 8'h3c);
    wr(10'h101, 8'h20);
    wr(10'h003, 8'h10);
    // Every owned channel pops a byte, so the payload is queued only once the frame pulse shows.
    for (i = 0; receive_frame_pulse_out !== 1'h1 && i < 20000; i++)
      @(posedge pclk);
    if (i == 20000)
      give_up("frame pulse timeout");
    push(8'h96);
    push(8'ha5);
    wait_cnt(1'h0, 40000);
    cmp("trunk in channel one", 32'h3c, {24'h0, frac_ch1});
    cmp("channel two payload", 32'ha5, {24'h0, frac_ch2});
    wr(10'h050, 8'h00);
    wait_cnt(1'h0, 40000);
    cmp("substitution off", 32'hff, {24'h0, frac_ch1});
    cmp("fifo drained", 32'h1, {31'h0, rx_byte_ready});
  endtask
  initial
  begin
    repeat (12) @(posedge pclk);
    presetn <= 1'h1;
    @(posedge pclk);
    t_regs;
    t_mux;
    t_frac;
    print_verdict;
  end
endmodule // rbfm_top_tb
